// >>> shared/pwat_map.svh
// register offsets, field positions and reset values of the translator
// How it works
// (R1) window hits when unmasked pci bits 31:20 equal enabled base bits
// (R2) table_mapping_select clear picks direct mapping, set picks table lookup
// (R3) direct address is translated base and pci bits merged by and-or
// (R4) size mask sets the split; all zeros 1mb, all ones 4gb
// (R5) software clears translated base bits below the split point
// (R6) physical address bits 39:33 always driven zero; mem_rd_addr zeroes only bits 39:34, its bit 33 is table base bit 33
// (R7) direct windows map only to regions aligned on the window size
// (R8) table mode reads the translated address from a map in memory
// (R9) translated base is table start, pci page bits index the entry
// (R10) each entry maps one 8kb pci page to one 8kb memory page
// (R11) entry is a quadword, bit 0 valid, bit 1 is address bit 13
// (R12) software writes zero into entry bits 63:22
// (R13) entry bits 21:1 give page, pci bits 12:5 appended below it
// (R14) software zeroes unused entry address bits on smaller systems
// (R15) table holds one eight-byte entry per 8kb window page
// (R16) entry address merges base bits 33:10 with pci bits 31:13
// (R17) entry with bit 0 clear raises invalid-entry exception
// (R18) one quadword read per lookup, request held until entry returns
`ifndef PWAT_MAP_SVH
`define PWAT_MAP_SVH
`define PWAT_NWIN 4
`define PWAT_WIN_STRIDE 8'h10
`define PWAT_OFS_BASE 4'h0
`define PWAT_OFS_MASK 4'h4
`define PWAT_OFS_TBASE 4'h8
`define PWAT_OFS_STS 8'h40
`define PWAT_OFS_IMASK 8'h44
`define PWAT_OFS_LAST_LO 8'h48
`define PWAT_OFS_LAST_HI 8'h4c
`define PWAT_OFS_INFO 8'h50
`define PWAT_BIT_EN 0
`define PWAT_BIT_SG 1
`define PWAT_FLD_HI 31
`define PWAT_FLD_LO 20
`define PWAT_TB_HI 23
`define PWAT_INF_IRQ 0
`define PWAT_INF_BUSY 1
`define PWAT_INF_RDY 2
`define PWAT_INF_WIN_LO 3
`define PWAT_INF_WIN_HI 4
`define PWAT_INF_SG 5
`define PWAT_INF_ERR 6
`define PWAT_INF_HIT 7
`define PWAT_EV_INVALID 0
`define PWAT_EV_MISS 1
`define PWAT_NEV 2
`define PWAT_RST_WORD 32'h0000_0000
`endif

// >>> shared/pwat_pkg.sv
// types of the pci window address translator
package pwat_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} pwat_state_e;
    typedef struct packed {
        logic en;
        logic sg;
        logic [11:0] base;
        logic [11:0] mask;
        logic [23:0] tbase;
    } pwat_win_s;
    typedef struct packed {
        logic hit;
        logic err;
        logic sg;
        logic [39:0] addr;
    } pwat_resp_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pwat_bus_s;
    typedef struct packed {
        pwat_win_s [3:0] win;
        logic [1:0] sts;
        logic [1:0] imask;
        pwat_state_e state;
        logic [1:0] wsel;
        logic [31:0] pci;
        pwat_resp_s resp;
        logic resp_v;
        logic rdy;
        logic mrd;
        logic [39:0] mrd_addr;
        logic [31:0] rdata;
        logic irq;
    } pwat_st_s;
endpackage

// >>> core/pwat_top.sv
// pci target window translator: direct and table mapping to memory
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "pwat_map.svh"
module pwat_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire pwat_pkg::pwat_bus_s bus,
    output logic [31:0] rd_data,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    output logic req_ready,
    output logic resp_valid,
    output pwat_pkg::pwat_resp_s resp,
    output logic mem_rd_req,
    output logic [39:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [63:0] mem_rd_data,
    output logic irq
);
    pwat_pkg::pwat_st_s s_q;
    pwat_pkg::pwat_st_s s_d;

    // per-window decode results
    logic [3:0] hit_w;
    logic [39:0] dir_w [4];
    logic [39:0] ent_w [4];

    genvar g;
    generate
        for (g = 0; g < `PWAT_NWIN; g++) begin : gw
            logic [11:0] m;
            logic [11:0] hi;
            logic [33:0] d;
            logic [33:0] e;
            assign m = s_q.win[g].mask;
            assign hit_w[g] = s_q.win[g].en
                & ((req_addr[31:20] & ~m) == (s_q.win[g].base & ~m)); // R1
            // base bits above the split, pci bits below; the base low
            // bits are cleared by the ~m mask in hardware
            assign hi = (s_q.win[g].tbase[21:10] & ~m) // R3 R4 R5
                | (req_addr[31:20] & m); // R3 R4
            assign d = {s_q.win[g].tbase[23:22], hi, req_addr[19:0]}; // R7
            assign dir_w[g] = {7'h00, d[32:0]}; // R6
            // table entry: one quadword per 8kb page of the window
            assign e = {s_q.win[g].tbase[23:12], // R9 R16
                (s_q.win[g].tbase[11:0] & ~m) | (req_addr[31:20] & m),
                req_addr[19:13], 3'h0}; // R10 R15 R16
            assign ent_w[g] = {6'h00, e};
        end
    endgenerate

    // lowest-numbered hit wins; overlapping windows are illegal anyway
    logic any_hit;
    logic [1:0] hit_idx;
    always_comb begin
        any_hit = 1'b0;
        hit_idx = 2'h0;
        for (int i = `PWAT_NWIN - 1; i >= 0; i--) begin
            if (hit_w[i]) begin
                any_hit = 1'b1;
                hit_idx = 2'(i);
            end
        end
    end

    // register write decode
    logic win_sel;
    logic [1:0] win_idx;
    logic [3:0] win_ofs;
    assign win_sel = (bus.addr[7:6] == 2'h0);
    assign win_idx = bus.addr[5:4];
    assign win_ofs = bus.addr[3:0];

    logic [`PWAT_NEV-1:0] ev;
    logic [`PWAT_NEV-1:0] clr;
    logic [33:0] page_addr;

    // physical address from a returned entry: page from bits 21:1
    assign page_addr = {mem_rd_data[21:1], s_q.pci[12:5], // R11 R13
        s_q.pci[4:0]};

    always_comb begin
        s_d = s_q;
        s_d.resp_v = 1'b0;
        s_d.mrd = 1'b0;
        s_d.rdata = `PWAT_RST_WORD;
        ev = '0;
        clr = '0;

        // register writes
        if (bus.wr) begin
            if (win_sel) begin
                unique case (win_ofs)
                    `PWAT_OFS_BASE: begin
                        s_d.win[win_idx].en = bus.wdata[`PWAT_BIT_EN];
                        s_d.win[win_idx].sg = bus.wdata[`PWAT_BIT_SG];
                        s_d.win[win_idx].base =
                            bus.wdata[`PWAT_FLD_HI:`PWAT_FLD_LO];
                    end
                    `PWAT_OFS_MASK: begin
                        s_d.win[win_idx].mask =
                            bus.wdata[`PWAT_FLD_HI:`PWAT_FLD_LO];
                    end
                    `PWAT_OFS_TBASE: begin
                        s_d.win[win_idx].tbase = bus.wdata[`PWAT_TB_HI:0];
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (bus.addr)
                    `PWAT_OFS_STS: begin
                        clr = bus.wdata[`PWAT_NEV-1:0];
                    end
                    `PWAT_OFS_IMASK: begin
                        s_d.imask = bus.wdata[`PWAT_NEV-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // register reads, answered one cycle later
        if (bus.rd) begin
            if (win_sel) begin
                unique case (win_ofs)
                    `PWAT_OFS_BASE: begin
                        s_d.rdata = {s_q.win[win_idx].base, 18'h00000,
                            s_q.win[win_idx].sg, s_q.win[win_idx].en};
                    end
                    `PWAT_OFS_MASK: begin
                        s_d.rdata = {s_q.win[win_idx].mask, 20'h00000};
                    end
                    `PWAT_OFS_TBASE: begin
                        s_d.rdata = {8'h00, s_q.win[win_idx].tbase};
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (bus.addr)
                    `PWAT_OFS_STS: begin
                        s_d.rdata = {30'h0, s_q.sts};
                    end
                    `PWAT_OFS_IMASK: begin
                        s_d.rdata = {30'h0, s_q.imask};
                    end
                    `PWAT_OFS_LAST_LO: begin
                        s_d.rdata = s_q.resp.addr[31:0];
                    end
                    `PWAT_OFS_LAST_HI: begin
                        s_d.rdata = {24'h0, s_q.resp.addr[39:32]};
                    end
                    `PWAT_OFS_INFO: begin
                        s_d.rdata[`PWAT_INF_IRQ] = s_q.irq;
                        s_d.rdata[`PWAT_INF_BUSY] =
                            (s_q.state == pwat_pkg::ST_WAIT);
                        s_d.rdata[`PWAT_INF_RDY] = s_q.rdy;
                        s_d.rdata[`PWAT_INF_WIN_HI:`PWAT_INF_WIN_LO] =
                            s_q.wsel;
                        s_d.rdata[`PWAT_INF_SG] = s_q.resp.sg;
                        s_d.rdata[`PWAT_INF_ERR] = s_q.resp.err;
                        s_d.rdata[`PWAT_INF_HIT] = s_q.resp.hit;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // translation sequence
        unique case (s_q.state)
            pwat_pkg::ST_IDLE: begin
                s_d.rdy = 1'b1;
                if (req_valid && s_q.rdy) begin
                    s_d.pci = req_addr;
                    s_d.wsel = hit_idx;
                    if (!any_hit) begin
                        // miss: answered at once, no translation
                        s_d.resp = '0;
                        s_d.resp_v = 1'b1;
                        ev[`PWAT_EV_MISS] = 1'b1;
                    end else if (!s_q.win[hit_idx].sg) begin
                        s_d.resp.hit = 1'b1; // R2
                        s_d.resp.err = 1'b0;
                        s_d.resp.sg = 1'b0;
                        s_d.resp.addr = dir_w[hit_idx]; // R3
                        s_d.resp_v = 1'b1;
                    end else begin
                        s_d.mrd = 1'b1; // R2 R8 R18
                        s_d.mrd_addr = ent_w[hit_idx]; // R9
                        s_d.rdy = 1'b0; // R18
                        s_d.state = pwat_pkg::ST_WAIT;
                    end
                end
            end
            pwat_pkg::ST_WAIT: begin
                s_d.rdy = 1'b0; // R18
                if (mem_rd_valid) begin
                    s_d.resp.hit = 1'b1;
                    s_d.resp.sg = 1'b1;
                    s_d.resp_v = 1'b1;
                    s_d.state = pwat_pkg::ST_IDLE;
                    if (mem_rd_data[0]) begin
                        s_d.resp.err = 1'b0; // R11
                        s_d.resp.addr = {7'h00, page_addr[32:0]}; // R6
                    end else begin
                        s_d.resp.err = 1'b1; // R17
                        s_d.resp.addr = '0;
                        ev[`PWAT_EV_INVALID] = 1'b1; // R17
                    end
                end
            end
        endcase

        // sticky events, a new event wins over a clear
        s_d.sts = (s_q.sts & ~clr) | ev;
        s_d.irq = |(s_d.sts & s_d.imask);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rdata;
    assign req_ready = s_q.rdy;
    assign resp_valid = s_q.resp_v;
    assign resp = s_q.resp;
    assign mem_rd_req = s_q.mrd;
    assign mem_rd_addr = s_q.mrd_addr;
    assign irq = s_q.irq;
endmodule

// >>> tb/pwat_chk.sv
// port assertions for the window translator
`timescale 1ns/10ps
module pwat_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire pwat_pkg::pwat_bus_s bus,
    input wire logic [31:0] rd_data,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire pwat_pkg::pwat_resp_s resp,
    input wire logic mem_rd_req,
    input wire logic [39:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [63:0] mem_rd_data,
    input wire logic irq
);
    logic [31:0] ad_q;
    logic [63:0] ent_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    always_ff @(posedge clk_sys) begin
        if (req_valid && req_ready) ad_q <= req_addr;
        if (mem_rd_valid) ent_q <= mem_rd_data;
    end
    top_zero_a: assert property (
        resp_valid |-> resp.addr[39:33] == 7'h0)
        else $error("high address bits set");
    entry_align_a: assert property (
        mem_rd_req |-> mem_rd_addr[2:0] == 3'h0
        && mem_rd_addr[39:34] == 6'h0)
        else $error("entry address misaligned");
    entry_index_a: assert property (
        mem_rd_req |-> mem_rd_addr[9:3] == ad_q[19:13])
        else $error("entry index wrong");
    take_answer_a: assert property (
        req_valid && req_ready |=> resp_valid != mem_rd_req)
        else $error("request not answered one way");
    one_read_a: assert property (
        !req_ready && $past(!req_ready) |-> !mem_rd_req)
        else $error("second table read");
    entry_answer_a: assert property (
        mem_rd_valid && !req_ready |=> resp_valid && resp.sg ##1 req_ready)
        else $error("no answer after entry");
    direct_low_a: assert property (
        resp_valid && resp.hit && !resp.sg |-> resp.addr[19:0] == ad_q[19:0])
        else $error("direct offset wrong");
    table_addr_a: assert property (
        resp_valid && resp.sg && !resp.err
        |-> resp.addr[32:0] == {ent_q[20:1], ad_q[12:0]})
        else $error("table address wrong");
    miss_zero_a: assert property (
        resp_valid && !resp.hit |-> resp.addr == 40'h0 && !resp.err)
        else $error("miss answer wrong");
endmodule
bind pwat_top pwat_chk i_chk (.clk_sys, .reset, .bus, .rd_data, .req_valid,
    .req_addr, .req_ready, .resp_valid, .resp, .mem_rd_req, .mem_rd_addr,
    .mem_rd_valid, .mem_rd_data, .irq);

// >>> tb/pwat_mem.sv
// memory side: answers each entry read after a chosen delay
`timescale 1ns/10ps
module pwat_mem (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mem_rd_req,
    input wire logic [39:0] mem_rd_addr,
    input wire logic [63:0] ent,
    input wire logic [2:0] lat,
    output logic mem_rd_valid = 1'b0,
    output logic [63:0] mem_rd_data = 64'h0,
    output logic [39:0] seen_addr
);
    logic [2:0] cnt;
    logic busy = 1'b0;
    always @(posedge clk_sys) begin
        mem_rd_valid <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        if (reset) begin
            busy <= 1'b0;
        end else if (mem_rd_req) begin
            busy <= 1'b1;
            cnt <= lat;
            seen_addr <= mem_rd_addr;
        end else if (busy && cnt == 3'h0) begin
            busy <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= ent;
        end else if (busy) begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule

// >>> tb/test_pwat_top.sv
// self-checking bench: random windows, direct and table lookups
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_pwat_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    pwat_pkg::pwat_bus_s bus = '0;
    logic req_valid = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic [31:0] rd_data;
    logic req_ready, resp_valid, mem_rd_req, mem_rd_valid, irq;
    pwat_pkg::pwat_resp_s resp;
    logic [39:0] mem_rd_addr, seen_addr;
    logic [63:0] mem_rd_data;
    logic [63:0] ent = 64'h0;
    logic [2:0] lat = 3'h0;
    logic [31:0] seed = 32'hd03cad0d;
    int err_total = 0;
    int n_compared = 0;
    pwat_top i_dut (.clk_sys, .reset, .bus, .rd_data, .req_valid, .req_addr,
        .req_ready, .resp_valid, .resp, .mem_rd_req, .mem_rd_addr,
        .mem_rd_valid, .mem_rd_data, .irq);
    pwat_mem i_mem (.clk_sys, .reset, .mem_rd_req, .mem_rd_addr, .ent, .lat,
        .mem_rd_valid, .mem_rd_data, .seen_addr);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [39:0] exp_addr(logic s, logic [23:0] t,
            logic [11:0] mk, logic [31:0] a, logic [63:0] e);
        if (s) return {7'h0, e[20:1], a[12:0]};
        return {7'h0, t[22], (t[21:10] & ~mk) | (a[31:20] & mk), a[19:0]};
    endfunction
    task automatic bus_op(input logic [7:0] a, input logic [31:0] d,
            input logic w, output logic [31:0] q);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys);
        bus <= '0;
        @(posedge clk_sys);
        q = rd_data;
    endtask
    task automatic xlate(input logic [31:0] a);
        int i;
        i = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_addr <= a;
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++i < 50);
        req_valid <= 1'b0;
        req_addr <= ~a;
        do @(posedge clk_sys); while (resp_valid !== 1'b1 && ++i < 90);
        if (resp_valid !== 1'b1) err_total++;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        report_and_stop();
    end
    initial begin
        logic [31:0] q, ad, tr, r, bw;
        logic [39:0] ea, es;
        logic [23:0] treg;
        logic [11:0] m;
        logic [1:0] w;
        logic sg;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        bus_op(8'h08, 32'h0, 1'b0, q);
        `CHK(q, 32'h0)
        bus_op(8'h60, 32'hffff_ffff, 1'b1, q);
        bus_op(8'h60, 32'h0, 1'b0, q);
        `CHK(q, 32'h0)
        for (int n = 0; n < 48; n++) begin
            w = n[1:0];
            sg = n[2];
            m = ~(12'hfff << (xs() % 13));
            ad = xs();
            tr = xs();
            r = xs();
            treg = sg ? {tr[23:12], tr[11:0] & ~m}
                : {tr[23:22], tr[21:10] & ~m, 10'h0};
            ent <= {42'h0, r[21:0]};
            lat <= r[24:22];
            bus_op({2'h0, w, 4'h8}, {8'h0, treg}, 1'b1, q);
            bus_op({2'h0, w, 4'h4}, {m, 20'h0}, 1'b1, q);
            bw = {ad[31:20] & ~m, 18'h0, sg, 1'b1};
            bus_op({2'h0, w, 4'h0}, bw, 1'b1, q);
            bus_op({2'h0, w, 4'h0}, 32'h0, 1'b0, q);
            `CHK(q, bw)
            xlate(ad);
            ea = exp_addr(sg, treg, m, ad, ent);
            es = {6'h0, treg[23:12], treg[11:0] | (ad[31:20] & m),
                ad[19:13], 3'h0};
            `CHK(resp.hit, 1'b1)
            `CHK(resp.sg, sg)
            if (sg) begin
                `CHK(seen_addr, es)
                `CHK(resp.err, !r[0])
            end
            if (!sg || r[0]) `CHK(resp.addr, ea)
            bus_op(8'h48, 32'h0, 1'b0, q);
            `CHK(q, (!sg || r[0]) ? ea[31:0] : 32'h0)
            xlate({ad[31:20] ^ ~m, ad[19:0]});
            `CHK(resp.hit, m == 12'hfff)
            bus_op({2'h0, w, 4'h0}, 32'h0, 1'b1, q);
        end
        bus_op(8'h44, 32'h0, 1'b1, q);
        bus_op(8'h40, 32'h3, 1'b1, q);
        bus_op(8'h40, 32'h0, 1'b0, q);
        `CHK(q, 32'h0)
        xlate(32'h1234_5678);
        bus_op(8'h50, 32'h0, 1'b0, q);
        `CHK(q, 32'h4)
        bus_op(8'h40, 32'h0, 1'b0, q);
        `CHK(q, 32'h2)
        `CHK(irq, 1'b0)
        bus_op(8'h44, 32'h2, 1'b1, q);
        `CHK(irq, 1'b1)
        bus_op(8'h40, 32'h2, 1'b1, q);
        `CHK(irq, 1'b0)
        report_and_stop();
    end
endmodule
